// [rtl/rsef_top.sv]
`timescale 1ns/1ps
`include "rsef_defs.svh"
// Contract
// [RULE1] one status register per axis, two addresses
// [RULE2] bit 13 shows enabled stall input
// [RULE3] software should enable stall stop
// [RULE4] reverse-move flag set, cleared on read
// [RULE5] zero-velocity bit when velocity equals zero
// [RULE6] position-match bit while actual equals target
// [RULE7] velocity-match bit while actual equals maximum
// [RULE8] position-reached event latched, read clears
// [RULE9] event flags ORed onto interrupt output
// [RULE10] stall-stop event flag on stall stop
// [RULE11] read clears stall-stop condition and interrupt
// [RULE12] right-stop event flag on right stop
// [RULE13] hold mode removes right-stop condition
// [RULE14] bit 11 shows standstill wait running
// [RULE15] read clears after read data captured
module rsef_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input rsef_pkg::rsef_req_t req_in,
  input rsef_pkg::rsef_axis_t axis1_in,
  input rsef_pkg::rsef_axis_t axis2_in,
  output logic [13:0] rdata_out,
  output logic rvalid_out,
  output logic irq_out
);
  logic [13:0] stat1;
  logic [13:0] stat2;
  logic irq1;
  logic irq2;
  logic clr1_d;
  logic clr2_d;

  // one decoder for both register addresses
  function automatic logic addr_hit(input rsef_pkg::rsef_req_t req, input logic [6:0] base);
    return req.rd_en & (req.addr == base);
  endfunction : addr_hit

  // address decode; clear strobes go to the axes in the read cycle,
  // and the returned word is sampled from the pre-clear snapshot
  always_comb begin
    clr1_d = addr_hit(req_in, `RSEF_ADDR_AXIS1); // [RULE1]
    clr2_d = addr_hit(req_in, `RSEF_ADDR_AXIS2); // [RULE1]
  end

  rsef_axis u_axis1 (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .axis_in(axis1_in),
    .rd_clear_in(clr1_d),
    .status_out(stat1),
    .irq_out(irq1)
  );
  rsef_axis u_axis2 (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .axis_in(axis2_in),
    .rd_clear_in(clr2_d),
    .status_out(stat2),
    .irq_out(irq2)
  );

  // read data capture
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out <= `RSEF_STAT_RESET;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd_en;
      if (clr1_d) begin
        rdata_out <= stat1; // [RULE15]
      end else if (clr2_d) begin
        rdata_out <= stat2; // [RULE15]
      end else begin
        rdata_out <= `RSEF_STAT_RESET;
      end
    end
  end

  // combined interrupt
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq1 | irq2; // [RULE9]
    end
  end

  a_read_axis1: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE15]
    clr1_d |=> (rdata_out == $past(stat1)))
    else $error("axis1 read data not pre-clear");
  a_unmapped_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE1]
    (req_in.rd_en && !clr1_d && !clr2_d) |=> (rdata_out == 14'h0000))
    else $error("unmapped read not zero");
  c_read1: cover property (@(posedge clk_in) clr1_d ##1 rvalid_out);

  // read port answers and the combined interrupt
  a_read_axis2: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE15]
    clr2_d |=> (rdata_out == $past(stat2)))
    else $error("axis2 read data not pre-clear");
  a_rvalid_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE1]
    req_in.rd_en |=> rvalid_out)
    else $error("read not answered");
  a_rvalid_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE1]
    !req_in.rd_en |=> !rvalid_out)
    else $error("answer without read");
  a_idle_rdata: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE1]
    !req_in.rd_en |=> (rdata_out == 14'h0000))
    else $error("read data not zero when idle");
  a_irq_combine: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE9]
    1'b1 |=> (irq_out == $past(irq1 | irq2)))
    else $error("interrupt not the or of both axes");
  c_read2: cover property (@(posedge clk_in) clr2_d ##1 rvalid_out);
  c_irq_raise: cover property (@(posedge clk_in) !irq_out ##1 irq_out);

  // axis1 live bits follow the inputs of the edge before
  a_ax1_stall: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE2]
    1'b1 |=> (stat1[`RSEF_BIT_STALL] ==
      $past(axis1_in.stall_active & axis1_in.stall_detect_enable)))
    else $error("axis1 stall bit wrong");
  a_ax1_zwait: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE14]
    1'b1 |=> (stat1[`RSEF_BIT_ZWAIT] == $past(axis1_in.zero_wait_running)))
    else $error("axis1 standstill wait bit wrong");
  a_ax1_vzero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE5]
    1'b1 |=> (stat1[`RSEF_BIT_VZERO] ==
      $past(axis1_in.actual_velocity == 32'h00000000)))
    else $error("axis1 zero velocity bit wrong");
  a_ax1_pos_match: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE6]
    1'b1 |=> (stat1[`RSEF_BIT_POS_MATCH] ==
      $past(axis1_in.actual_position == axis1_in.target_position)))
    else $error("axis1 position match bit wrong");
  a_ax1_vel_match: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE7]
    1'b1 |=> (stat1[`RSEF_BIT_VEL_MATCH] ==
      $past(axis1_in.actual_velocity == axis1_in.maximum_velocity)))
    else $error("axis1 velocity match bit wrong");
  a_ax1_stop_live: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE12]
    1'b1 |=> (stat1[`RSEF_BIT_STOP_R] == $past(axis1_in.right_stop_active)))
    else $error("axis1 right stop bit wrong");
  a_ax1_unused: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE1]
    (stat1 & 14'h001D) == 14'h0000)
    else $error("axis1 unused bits set");
  // axis1 event flags: set, read clear, hold clear and interrupt;
  // a flag caused at one edge shows in the snapshot two edges later
  a_ax1_pos_event: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE8]
    $rose(stat1[`RSEF_BIT_POS_MATCH]) |=> stat1[`RSEF_BIT_EV_POS])
    else $error("axis1 position event missing");
  a_ax1_sg_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE10]
    axis1_in.stall_stopped |=> ##1 stat1[`RSEF_BIT_EV_STOP_SG])
    else $error("axis1 stall stop event missing");
  a_ax1_sg_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE11]
    (clr1_d && stat1[`RSEF_BIT_EV_STOP_SG] && !axis1_in.stall_stopped)
      |=> ##1 !stat1[`RSEF_BIT_EV_STOP_SG])
    else $error("axis1 stall stop event not cleared");
  a_ax1_rev_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE4]
    axis1_in.reverse_move |=> ##1 stat1[`RSEF_BIT_REVERSE])
    else $error("axis1 reverse flag missing");
  a_ax1_rev_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE4]
    (clr1_d && stat1[`RSEF_BIT_REVERSE] && !axis1_in.reverse_move)
      |=> ##1 !stat1[`RSEF_BIT_REVERSE])
    else $error("axis1 reverse flag not cleared");
  a_ax1_rs_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE12]
    (axis1_in.right_stop_active && axis1_in.ramp_mode != `RSEF_RAMP_MODE_HOLD)
      |=> ##1 stat1[`RSEF_BIT_EV_STOP_R])
    else $error("axis1 right stop event missing");
  a_ax1_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE13]
    (axis1_in.ramp_mode == `RSEF_RAMP_MODE_HOLD) |=> ##1 !stat1[`RSEF_BIT_EV_STOP_R])
    else $error("axis1 hold mode kept right stop");
  a_ax1_irq_event: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE9]
    irq1 == (stat1[`RSEF_BIT_EV_POS] | stat1[`RSEF_BIT_EV_STOP_SG] | stat1[`RSEF_BIT_EV_STOP_R]))
    else $error("axis1 interrupt not the or of its events");

  // axis2 live bits follow the inputs of the edge before
  a_ax2_stall: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE2]
    1'b1 |=> (stat2[`RSEF_BIT_STALL] ==
      $past(axis2_in.stall_active & axis2_in.stall_detect_enable)))
    else $error("axis2 stall bit wrong");
  a_ax2_zwait: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE14]
    1'b1 |=> (stat2[`RSEF_BIT_ZWAIT] == $past(axis2_in.zero_wait_running)))
    else $error("axis2 standstill wait bit wrong");
  a_ax2_vzero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE5]
    1'b1 |=> (stat2[`RSEF_BIT_VZERO] ==
      $past(axis2_in.actual_velocity == 32'h00000000)))
    else $error("axis2 zero velocity bit wrong");
  a_ax2_pos_match: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE6]
    1'b1 |=> (stat2[`RSEF_BIT_POS_MATCH] ==
      $past(axis2_in.actual_position == axis2_in.target_position)))
    else $error("axis2 position match bit wrong");
  a_ax2_vel_match: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE7]
    1'b1 |=> (stat2[`RSEF_BIT_VEL_MATCH] ==
      $past(axis2_in.actual_velocity == axis2_in.maximum_velocity)))
    else $error("axis2 velocity match bit wrong");
  a_ax2_stop_live: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE12]
    1'b1 |=> (stat2[`RSEF_BIT_STOP_R] == $past(axis2_in.right_stop_active)))
    else $error("axis2 right stop bit wrong");
  a_ax2_unused: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE1]
    (stat2 & 14'h001D) == 14'h0000)
    else $error("axis2 unused bits set");
  // axis2 event flags: set, read clear, hold clear and interrupt;
  // a flag caused at one edge shows in the snapshot two edges later
  a_ax2_pos_event: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE8]
    $rose(stat2[`RSEF_BIT_POS_MATCH]) |=> stat2[`RSEF_BIT_EV_POS])
    else $error("axis2 position event missing");
  a_ax2_sg_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE10]
    axis2_in.stall_stopped |=> ##1 stat2[`RSEF_BIT_EV_STOP_SG])
    else $error("axis2 stall stop event missing");
  a_ax2_sg_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE11]
    (clr2_d && stat2[`RSEF_BIT_EV_STOP_SG] && !axis2_in.stall_stopped)
      |=> ##1 !stat2[`RSEF_BIT_EV_STOP_SG])
    else $error("axis2 stall stop event not cleared");
  a_ax2_rev_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE4]
    axis2_in.reverse_move |=> ##1 stat2[`RSEF_BIT_REVERSE])
    else $error("axis2 reverse flag missing");
  a_ax2_rev_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE4]
    (clr2_d && stat2[`RSEF_BIT_REVERSE] && !axis2_in.reverse_move)
      |=> ##1 !stat2[`RSEF_BIT_REVERSE])
    else $error("axis2 reverse flag not cleared");
  a_ax2_rs_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE12]
    (axis2_in.right_stop_active && axis2_in.ramp_mode != `RSEF_RAMP_MODE_HOLD)
      |=> ##1 stat2[`RSEF_BIT_EV_STOP_R])
    else $error("axis2 right stop event missing");
  a_ax2_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE13]
    (axis2_in.ramp_mode == `RSEF_RAMP_MODE_HOLD) |=> ##1 !stat2[`RSEF_BIT_EV_STOP_R])
    else $error("axis2 hold mode kept right stop");
  a_ax2_irq_event: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE9]
    irq2 == (stat2[`RSEF_BIT_EV_POS] | stat2[`RSEF_BIT_EV_STOP_SG] | stat2[`RSEF_BIT_EV_STOP_R]))
    else $error("axis2 interrupt not the or of its events");
endmodule : rsef_top

// [rtl/rsef_defs.svh]
`ifndef RSEF_DEFS_SVH
`define RSEF_DEFS_SVH
`define RSEF_ADDR_AXIS1 7'h35
`define RSEF_ADDR_AXIS2 7'h55
`define RSEF_STAT_WIDTH 14
`define RSEF_BIT_STOP_L 0
`define RSEF_BIT_STOP_R 1
`define RSEF_BIT_LATCH_L 2
`define RSEF_BIT_LATCH_R 3
`define RSEF_BIT_EV_STOP_L 4
`define RSEF_BIT_EV_STOP_R 5
`define RSEF_BIT_EV_STOP_SG 6
`define RSEF_BIT_EV_POS 7
`define RSEF_BIT_VEL_MATCH 8
`define RSEF_BIT_POS_MATCH 9
`define RSEF_BIT_VZERO 10
`define RSEF_BIT_ZWAIT 11
`define RSEF_BIT_REVERSE 12
`define RSEF_BIT_STALL 13
`define RSEF_STAT_RESET 14'h0000
`define RSEF_RAMP_MODE_HOLD 2'h3
`endif

// [rtl/rsef_pkg.sv]
package rsef_pkg;
  // live conditions delivered by the ramp generator of one axis
  typedef struct packed {
    logic stall_active;
    logic stall_detect_enable;
    logic stall_stopped;
    logic right_stop_active;
    logic reverse_move;
    logic zero_wait_running;
    logic [1:0] ramp_mode;
    logic [31:0] actual_position;
    logic [31:0] target_position;
    logic [31:0] actual_velocity;
    logic [31:0] maximum_velocity;
  } rsef_axis_t;
  // register read port request
  typedef struct packed {
    logic rd_en;
    logic [6:0] addr;
  } rsef_req_t;
endpackage : rsef_pkg

// [rtl/rsef_axis.sv]
`timescale 1ns/1ps
`include "rsef_defs.svh"
module rsef_axis (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input rsef_pkg::rsef_axis_t axis_in,
  input wire logic rd_clear_in,
  output logic [13:0] status_out,
  output logic irq_out
);
  logic rev_q;
  logic pos_ev_q;
  logic sg_ev_q;
  logic rs_ev_q;
  logic pos_match_q;
  logic [13:0] live_d;
  logic pos_match_d;

  // live comparisons
  always_comb begin
    pos_match_d = (axis_in.actual_position == axis_in.target_position); // [RULE6]
    live_d = `RSEF_STAT_RESET;
    live_d[`RSEF_BIT_STALL] = axis_in.stall_active & axis_in.stall_detect_enable; // [RULE2]
    live_d[`RSEF_BIT_REVERSE] = rev_q;
    live_d[`RSEF_BIT_ZWAIT] = axis_in.zero_wait_running; // [RULE14]
    live_d[`RSEF_BIT_VZERO] = (axis_in.actual_velocity == 32'h00000000); // [RULE5]
    live_d[`RSEF_BIT_POS_MATCH] = pos_match_d;
    live_d[`RSEF_BIT_VEL_MATCH] =
      (axis_in.actual_velocity == axis_in.maximum_velocity); // [RULE7]
    live_d[`RSEF_BIT_EV_POS] = pos_ev_q;
    live_d[`RSEF_BIT_EV_STOP_SG] = sg_ev_q;
    live_d[`RSEF_BIT_EV_STOP_R] = rs_ev_q;
    live_d[`RSEF_BIT_STOP_R] = axis_in.right_stop_active;
  end

  // status snapshot register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_out <= `RSEF_STAT_RESET;
      pos_match_q <= 1'b0;
    end else begin
      status_out <= live_d;
      pos_match_q <= pos_match_d;
    end
  end

  // sticky events, set wins over read clear; a read clears only the bits
  // that the returned snapshot carried, so a flag set just before is kept
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rev_q <= 1'b0;
      pos_ev_q <= 1'b0;
      sg_ev_q <= 1'b0;
      rs_ev_q <= 1'b0;
    end else begin
      rev_q <= axis_in.reverse_move
        | (rev_q & ~(rd_clear_in & status_out[`RSEF_BIT_REVERSE])); // [RULE4] [RULE15]
      pos_ev_q <= (pos_match_d & ~pos_match_q)
        | (pos_ev_q & ~(rd_clear_in & status_out[`RSEF_BIT_EV_POS])); // [RULE8] [RULE15]
      sg_ev_q <= axis_in.stall_stopped
        | (sg_ev_q & ~(rd_clear_in & status_out[`RSEF_BIT_EV_STOP_SG])); // [RULE10] [RULE11]
      rs_ev_q <= (axis_in.right_stop_active & (axis_in.ramp_mode != `RSEF_RAMP_MODE_HOLD))
        | (rs_ev_q & (axis_in.ramp_mode != `RSEF_RAMP_MODE_HOLD)); // [RULE12] [RULE13]
    end
  end

  // interrupt as or of the three event flags; the reverse flag is no source
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= pos_ev_q | sg_ev_q | rs_ev_q; // [RULE9]
    end
  end

  a_pos_event_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE8]
    (pos_match_d && !pos_match_q) |=> pos_ev_q)
    else $error("position event not latched");
  a_hold_clears_rs: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE13]
    (axis_in.ramp_mode == `RSEF_RAMP_MODE_HOLD) |=> !rs_ev_q)
    else $error("hold mode did not clear right stop");
  a_stall_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE10]
    axis_in.stall_stopped |=> sg_ev_q)
    else $error("stall stop not latched");
  a_rev_set: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE4]
    axis_in.reverse_move |=> rev_q)
    else $error("reverse flag not latched");
  a_irq_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE9]
    (pos_ev_q || sg_ev_q || rs_ev_q) |=> irq_out)
    else $error("interrupt missing");
  a_vzero_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [RULE5]
    (axis_in.actual_velocity == 32'h00000000) |=> status_out[`RSEF_BIT_VZERO])
    else $error("zero velocity bit wrong");
  c_pos_event: cover property (@(posedge clk_in) pos_ev_q ##1 rd_clear_in ##1 !pos_ev_q);
  c_stall_event: cover property (@(posedge clk_in) sg_ev_q ##1 !sg_ev_q);
endmodule : rsef_axis

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  rsef_pkg::rsef_req_t req = '0;
  rsef_pkg::rsef_axis_t ax [2];
  logic [13:0] rdata_out;
  logic rvalid_out;
  logic irq_out;
  logic [13:0] ev [2];
  logic pm [2];
  logic [31:0] r;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 97211;
  rsef_top i_rsef_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req),
    .axis1_in(ax[0]), .axis2_in(ax[1]), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .irq_out(irq_out));
  // 50 ns clock
  initial forever #25 clk_in = ~clk_in;
  // compare one value and count it
  task chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  // live bits of one axis worked out from its inputs
  function automatic logic [13:0] live(input int a);
    logic [13:0] v;
    v = '0;
    v[13] = ax[a].stall_active & ax[a].stall_detect_enable;
    v[11] = ax[a].zero_wait_running;
    v[10] = ax[a].actual_velocity == 0;
    v[9] = ax[a].actual_position == ax[a].target_position;
    v[8] = ax[a].actual_velocity == ax[a].maximum_velocity;
    v[1] = ax[a].right_stop_active;
    return v;
  endfunction : live
  // event flags of the model, set wins over read clear, hold mode wins
  task upd;
    logic [13:0] lv;
    for (int a = 0; a < 2; a++) begin
      lv = live(a);
      if (ax[a].reverse_move) ev[a][12] = 1'b1;
      if (lv[9] && !pm[a]) ev[a][7] = 1'b1;
      pm[a] = lv[9];
      if (ax[a].stall_stopped) ev[a][6] = 1'b1;
      if (ax[a].right_stop_active && ax[a].ramp_mode != 2'h3) ev[a][5] = 1'b1;
      if (ax[a].ramp_mode == 2'h3) ev[a][5] = 1'b0;
    end
  endtask : upd
  // one read; index 2 is an unmapped address
  task rd(input int a);
    logic [13:0] exp;
    @(posedge clk_in);
    #1 req = {1'b1, a == 0 ? 7'h35 : a == 1 ? 7'h55 : 7'h36};
    @(posedge clk_in);
    #1 req = '0;
    exp = a < 2 ? live(a) | ev[a] : 14'h0000;
    chk("rvalid", {13'h0000, rvalid_out}, 14'h0001);
    chk("rdata", rdata_out, exp);
    if (a < 2) ev[a] = ev[a] & ~14'h10C0;
  endtask : rd
  task irq_chk;
    chk("irq", {13'h0000, irq_out}, {13'h0000, |{ev[0][7:5], ev[1][7:5]}});
  endtask : irq_chk
  // random axis inputs with narrow ranges so matches occur often
  initial begin
    for (int a = 0; a < 2; a++) begin
      ax[a] = '0;
      ax[a].target_position = 32'h00000001;
      ev[a] = '0;
      pm[a] = 1'b0;
    end
    cyc(10);
    sys_rst_in = 1'b0;
    cyc(2);
    irq_chk();
    for (int i = 0; i < 40; i++) begin
      for (int a = 0; a < 2; a++) begin
        r = $random(seed);
        {ax[a].stall_active, ax[a].stall_detect_enable, ax[a].stall_stopped,
          ax[a].right_stop_active, ax[a].reverse_move, ax[a].zero_wait_running,
          ax[a].ramp_mode} = r[7:0];
        ax[a].actual_position = {31'h0, r[8]};
        ax[a].target_position = {31'h0, r[9]};
        ax[a].actual_velocity = {31'h0, r[10]};
        ax[a].maximum_velocity = {31'h0, r[11]};
      end
      cyc(4);
      upd();
      irq_chk();
      for (int a = 0; a < 3; a++) rd(a);
      cyc(4);
      upd();
      irq_chk();
      rd(0);
      rd(1);
      upd();
      $display("test step %0d done", i);
    end
    cyc(4);
    irq_chk();
    // short stall pulse: the live bit drops again before the read, the stop event keeps it
    ax[0] = '0;
    ax[0].target_position = 32'h00000001;
    ax[0].stall_detect_enable = 1'b1;
    cyc(4);
    upd();
    rd(0);
    ax[0].stall_active = 1'b1;
    ax[0].stall_stopped = 1'b1;
    cyc(1);
    ax[0].stall_active = 1'b0;
    ax[0].stall_stopped = 1'b0;
    ev[0][6] = 1'b1;
    cyc(4);
    upd();
    irq_chk();
    rd(0);
    $display("test stall pulse done");
    // reset in mid-run: outputs drop at once, flags start clean
    sys_rst_in = 1'b1;
    cyc(2);
    chk("rst rdata", rdata_out, 14'h0000);
    chk("rst rvalid", {13'h0000, rvalid_out}, 14'h0000);
    chk("rst irq", {13'h0000, irq_out}, 14'h0000);
    for (int a = 0; a < 2; a++) begin
      ev[a] = '0;
      pm[a] = 1'b0;
    end
    sys_rst_in = 1'b0;
    cyc(4);
    upd();
    irq_chk();
    rd(0);
    rd(1);
    $display("test mid-run reset done");
    tally_and_finish();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    tally_and_finish();
  end
endmodule : tb_top
